// ===== hw/irq_wake_params.svh
// constants of the interrupt and wake-up unit
`ifndef IRQ_WAKE_PARAMS_SVH
`define IRQ_WAKE_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_P1WAKE    8'h96
`define IDX_IE_MAIN   8'hA8
`define IDX_IE_EXT    8'hA9
`define IDX_PRIO_LA   8'hB8
`define IDX_PRIO_HA   8'hB9
`define IDX_PRIO_LB   8'hBA
`define IDX_PRIO_HB   8'hBB
`define IDX_FLAGS     8'hC0
`define IDX_TRIGGER   8'hC1
`define IDX_STATUS    8'hC2

// reset values and writable bit masks
`define RST_REG8      8'h00
`define RST_FLAGS     16'h0000
`define MASK_IE_MAIN  8'hBF
`define MASK_IE_EXT   8'h5F
`define MASK_PRIO_A   8'h3F
`define MASK_PRIO_B   8'h1F

// enable register bit positions
`define BIT_GLOBAL_EN 7
`define BIT_PROG_WE   6
`define BIT_PIN0_EN   0
`define BIT_PIN1_EN   2
`define BIT_T3_EN     0
`define BIT_P1_EN     1
`define BIT_PIN2_EN   2

// pending flag bit positions
`define FLG_PIN0      0
`define FLG_T0        1
`define FLG_PIN1      2
`define FLG_T1        3
`define FLG_RX        4
`define FLG_TX        5
`define FLG_T2        6
`define FLG_T2X       7
`define FLG_T3        8
`define FLG_P1        9
`define FLG_PIN2      10
`define FLG_ADC       11
`define FLG_TK        12
`define FLG_SPI       13
`define FLG_WRITE_COLLISION_FLAG      14
`define FLG_MODE_FAULT_FLAG      15

// source indices, in vector order
`define SRC_PIN0      4'h0
`define SRC_PIN1      4'h2
`define SRC_GAP       4'h6

// vector layout
`define VEC_BASE      16'h0003
`define VEC_STEP      16'h0008

// bus responses
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

// ===== hw/irq_wake_pkg.sv
// types shared by the interrupt and wake-up unit
package irq_wake_pkg;

	typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_STOP} power_t;

	typedef struct packed {
		logic timer0Ovf;
		logic timer1Ovf;
		logic timer2Ovf;
		logic timer2Ext;
		logic timer3Ovf;
		logic rxDone;
		logic txDone;
		logic adcDone;
		logic touchDone;
		logic spiDone;
		logic writeCollision;
		logic modeFault;
	} periph_evt_t;

	typedef struct packed {
		logic        irqReq;
		logic [1:0]  irqLevel;
		logic [15:0] irqVector;
	} cpu_req_t;

	typedef struct packed {
		logic irqAck;
		logic irqReturn;
		logic idleEntry;
		logic stopEntry;
	} cpu_ctl_t;

	// highest level currently in service, valid only when the mask is nonzero
	function automatic logic [1:0] topServiceLevel(input logic [3:0] inService);
		logic [1:0] lvl;
		lvl = 2'b00;
		for (int i = 0; i < 4; i++) begin
			if (inService[i]) begin
				lvl = 2'(i);
			end
		end
		return lvl;
	endfunction

endpackage

// ===== hw/pin_event_unit.sv
// edge and change detection for the external pins and port 1
`timescale 1ns/1ps
module pin_event_unit #(
	parameter int PORT_W = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic [2:0]        extPin,
	input  wire logic [PORT_W-1:0] port1Pin,
	input  wire logic [PORT_W-1:0] port1PinWakeMask,
	output logic      [2:0]        pinLow,
	output logic      [2:0]        pinFall,
	output logic                   port1Change
);
	logic [2:0]        pinPrev;
	logic [PORT_W-1:0] portPrev;
	logic              primed;
	logic [2:0]        next_pinPrev;
	logic [PORT_W-1:0] next_portPrev;
	logic              next_primed;

	always_comb begin
		next_pinPrev  = extPin;
		next_portPrev = port1Pin;
		next_primed   = 1'b1;
		pinLow        = ~extPin;
		pinFall       = pinPrev & ~extPin;
		// only pins enabled in the mask take part
		port1Change   = primed && (|((port1Pin ^ portPrev) & port1PinWakeMask)); // RQ13 RQ18
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pinPrev  <= 3'h7;
			portPrev <= '0;
			primed   <= 1'b0;
		end else begin
			pinPrev  <= next_pinPrev;
			portPrev <= next_portPrev;
			primed   <= next_primed;
		end
	end
endmodule

// ===== hw/priority_resolver.sv
// picks the request to present, against the levels in service
`timescale 1ns/1ps
module priority_resolver
	import irq_wake_pkg::*;
#(
	parameter int SRC_N = 11
) (
	input  wire logic [SRC_N-1:0] active,
	input  wire logic [SRC_N-1:0] prioHigh,
	input  wire logic [SRC_N-1:0] prioLow,
	input  wire logic [3:0]       inService,
	output logic                  grantValid,
	output logic      [3:0]       grantId,
	output logic      [1:0]       grantLevel
);
	logic found;

	always_comb begin
		found      = 1'b0;
		grantId    = 4'h0;
		grantLevel = 2'b00;
		// later hits win: highest level, then lowest index
		for (int lvl = 0; lvl < 4; lvl++) begin
			for (int i = SRC_N - 1; i >= 0; i--) begin
				if (active[i] && ({prioHigh[i], prioLow[i]} == 2'(lvl))) begin // RQ16
					found      = 1'b1;
					grantId    = 4'(i); // RQ20
					grantLevel = 2'(lvl);
				end
			end
		end
		// equal or higher level in service holds the request back
		grantValid = found && ((inService == 4'h0) ||
			(grantLevel > topServiceLevel(inService))); // RQ9 RQ10
	end
endmodule

// ===== hw/prioritized_interrupt_wake_unit.sv
// interrupt arbitration, vectoring and wake-up with an AXI4-Lite register slave
//
// Behaviour
// RQ1: eleven sources, four priority levels
// RQ2: any enabled request wakes core from Idle
// RQ3: only pin sources wake core from Stop
// RQ4: flags set whatever the enable bits
// RQ5: fixed vector per source from 0003 up
// RQ6: vector 0033 never given to a source
// RQ7: shared vectors OR their flags together
// RQ8: enables gate; priority registers give levels
// RQ9: equal or higher in service blocks new
// RQ10: higher level preempts; lower resumes afterwards
// RQ11: global enable off blocks every interrupt
// RQ12: pin enables gate interrupt and Stop wake
// RQ13: per-pin port-1 mask for change events
// RQ14: timer3 serviced only with its enable
// RQ15: port-1 change serviced only with enable
// RQ16: two priority bits form level 0..3
// RQ17: pin0/pin1 edge flags clear on service
// RQ18: port-1 any change; pin2 falling edge
// RQ19: Stop refused while enabled pin low
// RQ20: same level: lowest vector granted first
// RQ21: flag holds until service or software clear (level-mode pin0/pin1 flags follow the pin instead)
`timescale 1ns/1ps
`include "irq_wake_params.svh"
module prioritized_interrupt_wake_unit #(
	parameter int SRC_N  = 11,
	parameter int PORT_W = 8,
	parameter int ADDR_W = 12
) (
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	input  wire logic [ADDR_W-1:0]     awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic      [1:0]            bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [ADDR_W-1:0]     araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic      [31:0]           rdata,
	output logic      [1:0]            rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic [2:0]            extPin,
	input  wire logic [PORT_W-1:0]     port1Pin,
	input  wire irq_wake_pkg::periph_evt_t periphEvt,
	input  wire irq_wake_pkg::cpu_ctl_t    cpuCtl,
	output irq_wake_pkg::cpu_req_t         cpuReq,
	output irq_wake_pkg::power_t           powerState,
	output logic                       wakeup,
	output logic                       stopRefused,
	output logic                       progWriteEnable
);
	import irq_wake_pkg::*;

	function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
		return ADDR_W'({idx, 2'b00});
	endfunction

	// skips the slot kept for the debug monitor
	function automatic logic [15:0] vectorOf(input logic [3:0] id);
		logic [15:0] slot;
		slot = (id < `SRC_GAP) ? {12'h000, id} : 16'({12'h000, id} + 16'h0001); // RQ6
		return 16'(`VEC_BASE + 16'(slot * `VEC_STEP)); // RQ5
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// state
	logic [PORT_W-1:0] port1PinWakeMask;
	logic [7:0]        ieMain;
	logic [7:0]        ieExt;
	logic [7:0]        prioLowA;
	logic [7:0]        prioHighA;
	logic [7:0]        prioLowB;
	logic [7:0]        prioHighB;
	logic [1:0]        triggerSel;
	logic [15:0]       flags;
	logic [3:0]        inService;
	logic [3:0]        reqId;
	logic [PORT_W-1:0] next_port1PinWakeMask;
	logic [7:0]        next_ieMain;
	logic [7:0]        next_ieExt;
	logic [7:0]        next_prioLowA;
	logic [7:0]        next_prioHighA;
	logic [7:0]        next_prioLowB;
	logic [7:0]        next_prioHighB;
	logic [1:0]        next_triggerSel;
	logic [15:0]       next_flags;
	logic [3:0]        next_inService;
	logic [3:0]        next_reqId;
	cpu_req_t          next_cpuReq;
	power_t            next_powerState;
	logic              next_wakeup;
	logic              next_stopRefused;

	logic              awHeld;
	logic              wHeld;
	logic [ADDR_W-1:0] awAddrHeld;
	logic [31:0]       wDataHeld;
	logic [3:0]        wStrbHeld;
	logic              next_awHeld;
	logic              next_wHeld;
	logic [ADDR_W-1:0] next_awAddrHeld;
	logic [31:0]       next_wDataHeld;
	logic [3:0]        next_wStrbHeld;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_rvalid;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;

	//////////////////////////////////////////////////////////////////////////////
	// request formation
	logic [2:0]       pinLow;
	logic [2:0]       pinFall;
	logic             port1Change;
	logic [SRC_N-1:0] pending;
	logic [SRC_N-1:0] srcEnable;
	logic [SRC_N-1:0] active;
	logic             grantValid;
	logic [3:0]       grantId;
	logic [1:0]       grantLevel;
	logic             pinWake;
	logic             stopBlock;
	logic             ackTaken;
	logic             doWrite;

	pin_event_unit #(
		.PORT_W (PORT_W)
	) pinEvents (
		.ref_clk          (ref_clk),
		.arst_n           (arst_n),
		.extPin           (extPin),
		.port1Pin         (port1Pin),
		.port1PinWakeMask (port1PinWakeMask),
		.pinLow           (pinLow),
		.pinFall          (pinFall),
		.port1Change      (port1Change)
	);

	always_comb begin
		pending = {
			flags[`FLG_SPI] | flags[`FLG_WRITE_COLLISION_FLAG] | flags[`FLG_MODE_FAULT_FLAG],
			flags[`FLG_ADC] | flags[`FLG_TK],
			flags[`FLG_PIN2],
			flags[`FLG_P1],
			flags[`FLG_T3],
			flags[`FLG_T2] | flags[`FLG_T2X],
			flags[`FLG_RX] | flags[`FLG_TX],
			flags[`FLG_T1],
			flags[`FLG_PIN1],
			flags[`FLG_T0],
			flags[`FLG_PIN0]}; // RQ1 RQ7
		srcEnable = {ieExt[4:0], ieMain[5:0]}; // RQ8 RQ14 RQ15
		active    = pending & srcEnable & {SRC_N{ieMain[`BIT_GLOBAL_EN]}}; // RQ11
		pinWake   = (flags[`FLG_PIN0] & ieMain[`BIT_PIN0_EN]) |
			(flags[`FLG_PIN1] & ieMain[`BIT_PIN1_EN]) |
			(flags[`FLG_PIN2] & ieExt[`BIT_PIN2_EN]) |
			(flags[`FLG_P1] & ieExt[`BIT_P1_EN]); // RQ3 RQ12
		stopBlock = (pinLow[0] & ieMain[`BIT_PIN0_EN]) |
			(pinLow[1] & ieMain[`BIT_PIN1_EN]) |
			(pinLow[2] & ieExt[`BIT_PIN2_EN]); // RQ19
		ackTaken  = cpuCtl.irqAck && cpuReq.irqReq;
		doWrite   = awHeld && wHeld && !bvalid;
	end

	priority_resolver #(
		.SRC_N (SRC_N)
	) resolver (
		.active     (active),
		.prioHigh   ({prioHighB[4:0], prioHighA[5:0]}),
		.prioLow    ({prioLowB[4:0], prioLowA[5:0]}),
		.inService  (inService),
		.grantValid (grantValid),
		.grantId    (grantId),
		.grantLevel (grantLevel)
	);

	//////////////////////////////////////////////////////////////////////////////
	// registers, flags, service stack and power mode
	logic [15:0] flagSet;
	logic [15:0] flagClr;
	logic [7:0]  wByte0;

	always_comb begin
		next_port1PinWakeMask = port1PinWakeMask;
		next_ieMain           = ieMain;
		next_ieExt            = ieExt;
		next_prioLowA         = prioLowA;
		next_prioHighA        = prioHighA;
		next_prioLowB         = prioLowB;
		next_prioHighB        = prioHighB;
		next_triggerSel       = triggerSel;
		flagClr               = 16'h0000;
		wByte0                = wDataHeld[7:0];
		if (doWrite && wStrbHeld[0]) begin
			if (awAddrHeld == byteAddr(`IDX_P1WAKE)) begin
				next_port1PinWakeMask = PORT_W'(wByte0);
			end
			if (awAddrHeld == byteAddr(`IDX_IE_MAIN)) begin
				next_ieMain = wByte0 & `MASK_IE_MAIN;
			end
			if (awAddrHeld == byteAddr(`IDX_IE_EXT)) begin
				next_ieExt = wByte0 & `MASK_IE_EXT;
			end
			if (awAddrHeld == byteAddr(`IDX_PRIO_LA)) begin
				next_prioLowA = wByte0 & `MASK_PRIO_A;
			end
			if (awAddrHeld == byteAddr(`IDX_PRIO_HA)) begin
				next_prioHighA = wByte0 & `MASK_PRIO_A;
			end
			if (awAddrHeld == byteAddr(`IDX_PRIO_LB)) begin
				next_prioLowB = wByte0 & `MASK_PRIO_B;
			end
			if (awAddrHeld == byteAddr(`IDX_PRIO_HB)) begin
				next_prioHighB = wByte0 & `MASK_PRIO_B;
			end
			if (awAddrHeld == byteAddr(`IDX_TRIGGER)) begin
				next_triggerSel = wByte0[1:0];
			end
		end
		// software clears flags by writing ones
		if (doWrite && (awAddrHeld == byteAddr(`IDX_FLAGS))) begin
			flagClr[7:0]  = wStrbHeld[0] ? wDataHeld[7:0] : 8'h00;
			flagClr[15:8] = wStrbHeld[1] ? wDataHeld[15:8] : 8'h00;
		end
		// edge-mode pin flags clear on service entry
		if (ackTaken && triggerSel[0] && (reqId == `SRC_PIN0)) begin
			flagClr[`FLG_PIN0] = 1'b1; // RQ17
		end
		if (ackTaken && triggerSel[1] && (reqId == `SRC_PIN1)) begin
			flagClr[`FLG_PIN1] = 1'b1; // RQ17
		end
		// level mode: the flag follows the pin
		if (!triggerSel[0] && !pinLow[0]) begin
			flagClr[`FLG_PIN0] = 1'b1;
		end
		if (!triggerSel[1] && !pinLow[1]) begin
			flagClr[`FLG_PIN1] = 1'b1;
		end
		flagSet = {periphEvt.modeFault, periphEvt.writeCollision, periphEvt.spiDone,
			periphEvt.touchDone, periphEvt.adcDone, pinFall[2], port1Change,
			periphEvt.timer3Ovf, periphEvt.timer2Ext, periphEvt.timer2Ovf,
			periphEvt.txDone, periphEvt.rxDone, periphEvt.timer1Ovf,
			triggerSel[1] ? pinFall[1] : pinLow[1], periphEvt.timer0Ovf,
			triggerSel[0] ? pinFall[0] : pinLow[0]}; // RQ4 RQ18
		next_flags = (flags & ~flagClr) | flagSet; // RQ21

		// service stack: one bit per level, return pops the highest
		next_inService = inService;
		if (cpuCtl.irqReturn && (inService != 4'h0)) begin
			next_inService[topServiceLevel(inService)] = 1'b0; // RQ10
		end
		if (ackTaken) begin
			next_inService[cpuReq.irqLevel] = 1'b1;
		end

		// request withdrawn the cycle after the core takes it
		next_cpuReq.irqReq    = grantValid && !ackTaken;
		next_cpuReq.irqLevel  = grantLevel;
		next_cpuReq.irqVector = vectorOf(grantId);
		next_reqId            = grantId;

		next_powerState  = powerState;
		next_wakeup      = 1'b0;
		next_stopRefused = 1'b0;
		case (powerState)
			PWR_RUN: begin
				if (cpuCtl.stopEntry) begin
					if (stopBlock) begin
						next_stopRefused = 1'b1; // RQ19
					end else begin
						next_powerState = PWR_STOP;
					end
				end else if (cpuCtl.idleEntry) begin
					next_powerState = PWR_IDLE;
				end
			end
			PWR_IDLE: begin
				if (|active) begin
					next_powerState = PWR_RUN; // RQ2
					next_wakeup     = 1'b1;
				end
			end
			PWR_STOP: begin
				if (pinWake) begin
					next_powerState = PWR_RUN; // RQ3 RQ12
					next_wakeup     = 1'b1;
				end
			end
			default: begin
				next_powerState = PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			port1PinWakeMask <= '0;
			ieMain           <= `RST_REG8;
			ieExt            <= `RST_REG8;
			prioLowA         <= `RST_REG8;
			prioHighA        <= `RST_REG8;
			prioLowB         <= `RST_REG8;
			prioHighB        <= `RST_REG8;
			triggerSel       <= 2'b00;
			flags            <= `RST_FLAGS;
			inService        <= 4'h0;
			reqId            <= 4'h0;
			cpuReq           <= '0;
			powerState       <= PWR_RUN;
			wakeup           <= 1'b0;
			stopRefused      <= 1'b0;
		end else begin
			port1PinWakeMask <= next_port1PinWakeMask;
			ieMain           <= next_ieMain;
			ieExt            <= next_ieExt;
			prioLowA         <= next_prioLowA;
			prioHighA        <= next_prioHighA;
			prioLowB         <= next_prioLowB;
			prioHighB        <= next_prioHighB;
			triggerSel       <= next_triggerSel;
			flags            <= next_flags;
			inService        <= next_inService;
			reqId            <= next_reqId;
			cpuReq           <= next_cpuReq;
			powerState       <= next_powerState;
			wakeup           <= next_wakeup;
			stopRefused      <= next_stopRefused;
		end
	end

	assign progWriteEnable = ieExt[`BIT_PROG_WE];

	//////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a == byteAddr(`IDX_P1WAKE)) || (a == byteAddr(`IDX_IE_MAIN)) ||
			(a == byteAddr(`IDX_IE_EXT)) || (a == byteAddr(`IDX_PRIO_LA)) ||
			(a == byteAddr(`IDX_PRIO_HA)) || (a == byteAddr(`IDX_PRIO_LB)) ||
			(a == byteAddr(`IDX_PRIO_HB)) || (a == byteAddr(`IDX_FLAGS)) ||
			(a == byteAddr(`IDX_TRIGGER)) || (a == byteAddr(`IDX_STATUS));
	endfunction

	always_comb begin
		awready         = !awHeld && !bvalid;
		wready          = !wHeld && !bvalid;
		arready         = !rvalid;
		next_awHeld     = awHeld;
		next_wHeld      = wHeld;
		next_awAddrHeld = awAddrHeld;
		next_wDataHeld  = wDataHeld;
		next_wStrbHeld  = wStrbHeld;
		next_bvalid     = bvalid;
		next_bresp      = bresp;
		next_rvalid     = rvalid;
		next_rdata      = rdata;
		next_rresp      = rresp;
		if (awvalid && awready) begin
			next_awHeld     = 1'b1;
			next_awAddrHeld = {awaddr[ADDR_W-1:2], 2'b00};
		end
		if (wvalid && wready) begin
			next_wHeld     = 1'b1;
			next_wDataHeld = wdata;
			next_wStrbHeld = wstrb;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = mapped(awAddrHeld) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp  = mapped({araddr[ADDR_W-1:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
			case ({araddr[ADDR_W-1:2], 2'b00})
				byteAddr(`IDX_P1WAKE):  next_rdata = 32'(port1PinWakeMask);
				byteAddr(`IDX_IE_MAIN): next_rdata = {24'h000000, ieMain};
				byteAddr(`IDX_IE_EXT):  next_rdata = {24'h000000, ieExt};
				byteAddr(`IDX_PRIO_LA): next_rdata = {24'h000000, prioLowA};
				byteAddr(`IDX_PRIO_HA): next_rdata = {24'h000000, prioHighA};
				byteAddr(`IDX_PRIO_LB): next_rdata = {24'h000000, prioLowB};
				byteAddr(`IDX_PRIO_HB): next_rdata = {24'h000000, prioHighB};
				byteAddr(`IDX_FLAGS):   next_rdata = {16'h0000, flags};
				byteAddr(`IDX_TRIGGER): next_rdata = {30'h0, triggerSel};
				byteAddr(`IDX_STATUS):  next_rdata = {16'h0000, reqId, 2'b00,
					powerState, 4'h0, inService};
				default:                next_rdata = 32'h00000000;
			endcase
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld     <= 1'b0;
			wHeld      <= 1'b0;
			awAddrHeld <= '0;
			wDataHeld  <= 32'h00000000;
			wStrbHeld  <= 4'h0;
			bvalid     <= 1'b0;
			bresp      <= `RESP_OKAY;
			rvalid     <= 1'b0;
			rdata      <= 32'h00000000;
			rresp      <= `RESP_OKAY;
		end else begin
			awHeld     <= next_awHeld;
			wHeld      <= next_wHeld;
			awAddrHeld <= next_awAddrHeld;
			wDataHeld  <= next_wDataHeld;
			wStrbHeld  <= next_wStrbHeld;
			bvalid     <= next_bvalid;
			bresp      <= next_bresp;
			rvalid     <= next_rvalid;
			rdata      <= next_rdata;
			rresp      <= next_rresp;
		end
	end
endmodule

// ===== tb/irq_wake_checker.sv
// assertions on the ports of the interrupt and wake-up unit
`timescale 1ns/1ps
module irq_wake_checker #(
	parameter int PORT_W = 8
) (
	input wire logic                   ref_clk,
	input wire logic                   arst_n,
	input wire logic [2:0]             extPin,
	input wire logic [PORT_W-1:0]      port1Pin,
	input wire irq_wake_pkg::cpu_ctl_t cpuCtl,
	input wire irq_wake_pkg::cpu_req_t cpuReq,
	input wire irq_wake_pkg::power_t   powerState,
	input wire logic                   wakeup,
	input wire logic                   stopRefused
);
	import irq_wake_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// stopped long enough that any earlier pin event has already acted, pins quiet
	sequence quietStop;
		(powerState == PWR_STOP) [*3] ##0 (extPin == 3'h7 && $past(extPin) == 3'h7
			&& $stable(port1Pin) && $past(port1Pin) == $past(port1Pin, 2));
	endsequence
	vec_reserved_a: assert property (cpuReq.irqReq |-> cpuReq.irqVector != 16'h0033)
		else $error("reserved vector presented");
	vec_form_a: assert property (cpuReq.irqReq |->
		cpuReq.irqVector[2:0] == 3'h3 && cpuReq.irqVector <= 16'h005B)
		else $error("vector outside table");
	ack_drop_a: assert property (cpuReq.irqReq && cpuCtl.irqAck |=> !cpuReq.irqReq)
		else $error("request stands after ack");
	idle_wake_a: assert property (wakeup |->
		powerState == PWR_RUN && $past(powerState) != PWR_RUN)
		else $error("wake pulse without leaving sleep");
	wake_pulse_a: assert property (wakeup |=> !wakeup)
		else $error("wake pulse too long");
	stop_refuse_a: assert property (stopRefused |->
		$past(cpuCtl.stopEntry) && powerState == PWR_RUN)
		else $error("bad stop refusal");
	stop_enter_a: assert property (powerState == PWR_RUN && cpuCtl.stopEntry |=>
		(powerState == PWR_STOP) != stopRefused)
		else $error("stop neither entered nor refused");
	stop_hold_a: assert property (quietStop |=> powerState == PWR_STOP)
		else $error("left stop without pin event");
	wake_flag_a: assert property (powerState != PWR_RUN |=>
		wakeup == (powerState == PWR_RUN))
		else $error("left sleep without wake pulse");
endmodule
bind prioritized_interrupt_wake_unit irq_wake_checker #(.PORT_W(PORT_W)) chk (.*);

// ===== tb/cpu_core_model.sv
// core-side model: acknowledges requests, issues returns and power commands
`timescale 1ns/1ps
module cpu_core_model (
	input  wire logic                   ref_clk,
	input  wire logic                   arst_n,
	input  wire irq_wake_pkg::cpu_req_t cpuReq,
	input  wire logic [3:0]             ackDelay,
	input  wire logic [2:0]             cmd,
	output irq_wake_pkg::cpu_ctl_t      cpuCtl,
	output logic      [15:0]            ackVec,
	output logic      [7:0]             ackCnt
);
	import irq_wake_pkg::*;
	logic [3:0] waitCnt;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpuCtl <= '0;
			ackVec <= '0;
			ackCnt <= '0;
			waitCnt <= '0;
		end else begin
			// ack only after the request has stood ackDelay cycles
			cpuCtl.irqAck <= cpuReq.irqReq && !cpuCtl.irqAck && waitCnt >= ackDelay;
			waitCnt <= cpuReq.irqReq ? waitCnt + 4'h1 : 4'h0;
			{cpuCtl.irqReturn, cpuCtl.idleEntry, cpuCtl.stopEntry} <= cmd;
			if (cpuCtl.irqAck && cpuReq.irqReq) begin
				ackVec <= cpuReq.irqVector;
				ackCnt <= ackCnt + 8'h01;
			end
		end
	end
endmodule

// ===== tb/prioritized_interrupt_wake_unit_tb_top.sv
// self-checking bench for the interrupt and wake-up unit
`timescale 1ns/1ps
`include "irq_wake_params.svh"
module prioritized_interrupt_wake_unit_tb_top;
	import irq_wake_pkg::*;
	logic        ref_clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, wakeup, stopRefused, progWriteEnable;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, ackDelay;
	logic [1:0]  bresp, rresp;
	logic [2:0]  extPin, cmd;
	logic [7:0]  port1Pin, ackCnt;
	logic [15:0] ackVec;
	periph_evt_t periphEvt;
	cpu_ctl_t    cpuCtl;
	cpu_req_t    cpuReq;
	power_t      powerState;
	int          n_fail, comparisons;
	logic [7:0]  vtab [16] = '{8'h0B, 8'h1B, 8'h2B, 8'h2B, 8'h3B, 8'h23, 8'h23, 8'h53,
		8'h53, 8'h5B, 8'h5B, 8'h5B, 8'h03, 8'h13, 8'h4B, 8'h43};
	prioritized_interrupt_wake_unit uut (.*);
	cpu_core_model core_model (.*);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task tmo(input int n);
		if (n >= 100) begin
			n_fail++;
			wrap_up;
		end
	endtask
	task wr(input logic [7:0] idx, input logic [31:0] d);
		int n;
		logic a, w, b;
		logic [1:0] r;
		@(posedge ref_clk);
		awaddr <= 12'({idx, 2'b00});
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge ref_clk);
			a = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge ref_clk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) break;
		end
		bready <= 1'b0;
		tmo(n);
		chk("bresp", 32'(r), 32'(`RESP_OKAY));
	endtask
	task rc(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
		int n;
		logic a, v;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge ref_clk);
		araddr <= 12'({idx, 2'b00});
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge ref_clk);
			a = arvalid && arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (a) arvalid <= 1'b0;
			if (v) break;
		end
		rready <= 1'b0;
		tmo(n);
		chk("rdata", d, e);
		chk("rresp", 32'(r), 32'(er));
	endtask
	task core(input logic [2:0] c);
		@(posedge ref_clk);
		cmd <= c;
		@(posedge ref_clk);
		cmd <= 3'h0;
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task evt(input int i);
		@(posedge ref_clk);
		if (i < 12) periphEvt <= periph_evt_t'(12'h800 >> i);
		else if (i < 15) extPin[i-12] <= 1'b0;
		else port1Pin <= ~port1Pin;
		@(posedge ref_clk);
		periphEvt <= '0;
		extPin <= 3'h7;
	endtask
	task ack_exp(input logic [15:0] v);
		int n;
		logic [7:0] c0;
		c0 = ackCnt;
		for (n = 0; n < 100 && ackCnt === c0; n++) @(posedge ref_clk);
		tmo(n);
		chk("vector", 32'(ackVec), 32'(v));
	endtask
	task wait_pwr(input power_t p);
		int n;
		for (n = 0; n < 100 && powerState !== p; n++) @(negedge ref_clk);
		tmo(n);
		chk("power", 32'(powerState), 32'(p));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task reg_reset;
		rc(`IDX_P1WAKE, 32'h0, `RESP_OKAY);
		rc(`IDX_IE_MAIN, 32'h0, `RESP_OKAY);
		rc(8'h10, 32'h0, `RESP_SLVERR);
		wr(`IDX_IE_EXT, 32'hFF);
		rc(`IDX_IE_EXT, 32'h5F, `RESP_OKAY);
		chk("progWriteEnable", 32'(progWriteEnable), 32'h1);
		wr(`IDX_IE_EXT, 32'h0);
		evt(0);
		rc(`IDX_FLAGS, 32'h2, `RESP_OKAY);
		wr(`IDX_IE_MAIN, 32'h02);
		rc(`IDX_FLAGS, 32'h2, `RESP_OKAY);
		chk("irqReq", 32'(cpuReq.irqReq), 32'h0);
		wr(`IDX_IE_MAIN, 32'h82);
		ack_exp(16'h000B);
		rc(`IDX_FLAGS, 32'h2, `RESP_OKAY);
		wr(`IDX_FLAGS, 32'hFFFF);
		core(3'h4);
	endtask
	task all_vectors;
		wr(`IDX_IE_MAIN, 32'hBF);
		wr(`IDX_IE_EXT, 32'h1F);
		wr(`IDX_P1WAKE, 32'h01);
		wr(`IDX_TRIGGER, 32'h3);
		ackDelay <= 4'h3;
		for (int i = 0; i < 16; i++) begin
			evt(i);
			ack_exp({8'h00, vtab[i]});
			if (i == 12) rc(`IDX_FLAGS, 32'h0, `RESP_OKAY);
			wr(`IDX_FLAGS, 32'hFFFF);
			core(3'h4);
		end
		ackDelay <= 4'h0;
	endtask
	task nesting;
		@(posedge ref_clk);
		periphEvt <= periph_evt_t'(12'hC00);
		@(posedge ref_clk);
		periphEvt <= '0;
		ack_exp(16'h000B);
		repeat (20) @(posedge ref_clk);
		chk("irqReq", 32'(cpuReq.irqReq), 32'h0);
		wr(`IDX_PRIO_HA, 32'h08);
		ack_exp(16'h001B);
		wr(`IDX_FLAGS, 32'hFFFF);
		core(3'h4);
		core(3'h4);
		wr(`IDX_PRIO_HA, 32'h00);
	endtask
	task power;
		wr(`IDX_IE_MAIN, 32'h82);
		core(3'h2);
		chk("power", 32'(powerState), 32'(PWR_IDLE));
		evt(0);
		ack_exp(16'h000B);
		wait_pwr(PWR_RUN);
		wr(`IDX_FLAGS, 32'hFFFF);
		core(3'h4);
		wr(`IDX_TRIGGER, 32'h0);
		wr(`IDX_IE_MAIN, 32'h01);
		core(3'h1);
		wait_pwr(PWR_STOP);
		evt(0);
		repeat (5) @(posedge ref_clk);
		wait_pwr(PWR_STOP);
		evt(12);
		wait_pwr(PWR_RUN);
		@(posedge ref_clk);
		extPin <= 3'h6;
		core(3'h1);
		chk("power", 32'(powerState), 32'(PWR_RUN));
		chk("stopRefused", 32'(stopRefused), 32'h1);
		@(posedge ref_clk);
		extPin <= 3'h7;
		rc(`IDX_FLAGS, 32'h2, `RESP_OKAY);
		wr(`IDX_FLAGS, 32'hFFFF);
	endtask
	initial begin
		arst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		extPin = 3'h7;
		port1Pin = 8'h00;
		periphEvt = '0;
		cmd = 3'h0;
		ackDelay = 4'h0;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		reg_reset;
		all_vectors;
		nesting;
		power;
		wrap_up;
	end
endmodule
